// ### design/gdfr_fault_resp.sv
// gdfr_fault_resp: fault response logic of a three-phase gate driver.
// assumes detector flags and pwm pins are asynchronous levels, the
// enable reset pulse comes from logic on sys_clk_in, and a sleep entry
// drives rst_b_in low.
// Operation
// - overcurrent turn-off uses dedicated soft sequence
// - soft turn-off applies reduced sink code
// - sink below 1100 mA: use minimum code
// - sink at least 1100 mA: minus seven
// - thermal warning sets status, no action
// - warning status follows detector, not latched
// - warning report bit adds pin and fault
// - thermal shutdown: drivers off, pump off, report
// - thermal shutdown recovers automatically when cool
// - shutdown status sticky until clear command
// - thermal shutdown response cannot be disabled
// - shunt overcurrent ignored if mode off/disabled
// - pump/regulator undervoltage: hi-z unless disabled
// - latched mode holds until clear after removal
// - retry mode clears after retry period
// - report mode reports only, drivers keep running
// - pwm rising edge clears overcurrent in cbc
`timescale 1ns/1ps
`default_nettype none
module gdfr_fault_resp #(
  parameter int unsigned RETRY_CYCLES = gdfr_pkg::RETRY_CYCLES_DFLT
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic [gdfr_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [gdfr_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [gdfr_pkg::DATA_W-1:0] reg_rdata_out,
  input wire logic drain_source_overcurrent_in,
  input wire logic shunt_overcurrent_in,
  input wire logic gate_drive_fail_in,
  input wire logic main_supply_undervolt_in,
  input wire logic drain_sense_undervolt_in,
  input wire logic charge_pump_undervolt_in,
  input wire logic lowside_reg_undervolt_in,
  input wire logic thermal_warn_in,
  input wire logic thermal_shutdown_in,
  input wire logic [gdfr_pkg::NUM_PWM-1:0] pwm_in,
  input wire logic enable_reset_pulse_in,
  output logic fault_out_n,
  output logic gate_hiz_out,
  output logic charge_pump_off_out,
  output logic soft_off_out,
  output logic [3:0] sink_code_out
);
  import gdfr_pkg::*;

  if (RETRY_CYCLES < 2)
  begin : g_chk
    $error("gdfr_fault_resp: RETRY_CYCLES must be at least 2");
  end

  ////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [IN_W-1:0] raw_w;
  logic [IN_W-1:0] syn_w;
  assign raw_w = {pwm_in, thermal_shutdown_in, thermal_warn_in,
                  lowside_reg_undervolt_in, charge_pump_undervolt_in,
                  drain_sense_undervolt_in, main_supply_undervolt_in,
                  gate_drive_fail_in, shunt_overcurrent_in,
                  drain_source_overcurrent_in};

  gdfr_sync #(
    .WIDTH(IN_W)
  ) u_sync (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .async_in(raw_w),
    .sync_out(syn_w)
  );

  wire vds_s = syn_w[0];
  wire sen_s = syn_w[1];
  wire gdf_s = syn_w[2];
  wire main_supply_undervolt_s = syn_w[3];
  wire drain_sense_undervolt_s = syn_w[4];
  wire charge_pump_undervolt_s = syn_w[5];
  wire lowside_reg_undervolt_s = syn_w[6];
  wire warn_s = syn_w[7];
  wire thermal_shutdown_s = syn_w[8];
  wire [NUM_PWM-1:0] pwm_s = syn_w[IN_W-1:9];

  logic [NUM_PWM-1:0] pwm_d_r;

  ////////////////////////////////////////////////////////////////////
  // register port decode
  logic [DATA_W-1:0] ctrl_r;
  logic [DATA_W-1:0] rdata_r;
  logic clr_pulse_r;

  wire wr_ctrl = reg_wr_in && (reg_addr_in == ADDR_CTRL);
  wire rd_ctrl = reg_rd_in && (reg_addr_in == ADDR_CTRL);
  wire rd_stat = reg_rd_in && (reg_addr_in == ADDR_STATUS);

  wire [3:0] prog_sink_w = ctrl_r[CTRL_SINK_LSB +: 4];
  wire [1:0] mode_w = ctrl_r[CTRL_MODE_LSB +: 2];
  wire shunt_overcurrent_disable_w = ctrl_r[CTRL_SHUNT_OVERCURRENT_DISABLE];
  wire gate_supply_uv_disable_w = ctrl_r[CTRL_GATE_SUPPLY_UV_DISABLE];
  wire gate_drive_fail_disable_w = ctrl_r[CTRL_GATE_DRIVE_FAIL_DISABLE];
  wire warn_rep_w = ctrl_r[CTRL_WARN_REP];
  wire cbc_en_w = ctrl_r[CTRL_CBC_EN];

  // either clear source acts the same way
  wire clear_cmd_w = clr_pulse_r || enable_reset_pulse_in;

  ////////////////////////////////////////////////////////////////////
  // overcurrent response
  gdfr_oc_e oc_r;
  gdfr_oc_e oc_nxt;
  logic vds_lat_r;
  logic sen_lat_r;
  logic retry_start_w;
  logic retry_done_w;

  wire mode_on = (mode_w != GDFR_OCP_OFF);
  wire vds_evt = vds_s && mode_on;
  wire sen_evt = sen_s && mode_on && !shunt_overcurrent_disable_w;
  wire ocp_evt = vds_evt || sen_evt;
  wire ocp_live = vds_s || sen_s;
  wire pwm_rise = |(pwm_s & ~pwm_d_r);
  wire cbc_clr = cbc_en_w && pwm_rise;
  wire trip_clr = (clear_cmd_w || cbc_clr) && !ocp_live;
  wire oc_active = (oc_r != GDFR_OC_CLEAR);
  wire oc_shut_mode = (mode_w == GDFR_OCP_LATCH) || (mode_w == GDFR_OCP_RETRY);
  wire ocp_shut_w = oc_active && oc_shut_mode;

  always_comb
  begin
    oc_nxt = oc_r;
    retry_start_w = 1'b0;
    case (oc_r)
      GDFR_OC_CLEAR:
      begin
        if (ocp_evt && mode_w == GDFR_OCP_RETRY)
        begin
          oc_nxt = GDFR_OC_RETRY;
          retry_start_w = 1'b1;
        end
        else if (ocp_evt)
          oc_nxt = GDFR_OC_TRIP;
      end
      GDFR_OC_TRIP:
      begin
        if (trip_clr && !ocp_evt)
          oc_nxt = GDFR_OC_CLEAR;
      end
      GDFR_OC_RETRY:
      begin
        if (retry_done_w && !ocp_evt)
          oc_nxt = GDFR_OC_CLEAR;
        else if (retry_done_w)
          retry_start_w = 1'b1;
      end
      default:
        oc_nxt = GDFR_OC_CLEAR;
    endcase
  end

  gdfr_retry_timer #(
    .CYCLES(RETRY_CYCLES)
  ) u_retry (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .start_in(retry_start_w),
    .busy_out(),
    .done_out(retry_done_w)
  );

  ////////////////////////////////////////////////////////////////////
  // other fault sources
  logic gdf_lat_r;
  logic tsd_lat_r;

  wire uv_hard = main_supply_undervolt_s || drain_sense_undervolt_s;
  wire uv_gd = (charge_pump_undervolt_s || lowside_reg_undervolt_s) && !gate_supply_uv_disable_w;
  wire uv_w = uv_hard || uv_gd;
  wire warn_rep_act = warn_s && warn_rep_w;
  wire thermal_shutdown_act = thermal_shutdown_s;

  wire fault_any_w = uv_w || oc_active || gdf_lat_r || thermal_shutdown_act
                     || warn_rep_act;
  wire hiz_w = uv_w || ocp_shut_w || gdf_lat_r || thermal_shutdown_act;

  wire soft_w = ocp_shut_w;
  wire [3:0] soft_code_w = (prog_sink_w >= SINK_CODE_1100MA) ?
                           (prog_sink_w - SINK_STEP_DOWN) : SINK_CODE_MIN;
  wire [3:0] sink_nxt = soft_w ? soft_code_w : prog_sink_w;
  // warning bit is live, never latched
  wire [DATA_W-1:0] stat_w = DATA_W'({hiz_w, uv_w, warn_s, tsd_lat_r,
                                      gdf_lat_r, sen_lat_r, vds_lat_r,
                                      fault_any_w});
  wire [DATA_W-1:0] rdata_nxt = rd_ctrl ? ctrl_r : (rd_stat ? stat_w : '0);

  ////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      ctrl_r <= CTRL_RESET;
      clr_pulse_r <= 1'b0;
      rdata_r <= '0;
      pwm_d_r <= '0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_r <= reg_wdata_in & CTRL_WMASK;
      clr_pulse_r <= wr_ctrl && reg_wdata_in[CTRL_CLEAR];
      rdata_r <= rdata_nxt;
      pwm_d_r <= pwm_s;
    end
  end

  // sticky fault bits; a new event wins over a clear
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      oc_r <= GDFR_OC_CLEAR;
      vds_lat_r <= 1'b0;
      sen_lat_r <= 1'b0;
      gdf_lat_r <= 1'b0;
      tsd_lat_r <= 1'b0;
    end
    else
    begin
      oc_r <= oc_nxt;
      vds_lat_r <= vds_evt || (vds_lat_r && oc_nxt != GDFR_OC_CLEAR);
      sen_lat_r <= sen_evt || (sen_lat_r && oc_nxt != GDFR_OC_CLEAR);
      gdf_lat_r <= (gdf_s && !gate_drive_fail_disable_w) ||
                   (gdf_lat_r && !(clear_cmd_w && !gdf_s));
      tsd_lat_r <= thermal_shutdown_s || (tsd_lat_r && !clear_cmd_w);
    end
  end

  // outputs, all registered
  logic fault_n_r;
  logic hiz_r;
  logic cp_off_r;
  logic soft_r;
  logic [3:0] sink_r;

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      fault_n_r <= 1'b1;
      hiz_r <= 1'b0;
      cp_off_r <= 1'b0;
      soft_r <= 1'b0;
      sink_r <= CTRL_RESET[CTRL_SINK_LSB +: 4];
    end
    else
    begin
      fault_n_r <= !fault_any_w;
      hiz_r <= hiz_w;
      cp_off_r <= thermal_shutdown_act;
      soft_r <= soft_w;
      sink_r <= sink_nxt;
    end
  end

  assign reg_rdata_out = rdata_r;
  assign fault_out_n = fault_n_r;
  assign gate_hiz_out = hiz_r;
  assign charge_pump_off_out = cp_off_r;
  assign soft_off_out = soft_r;
  assign sink_code_out = sink_r;

  ////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  a_soft_on_trip: assert property (
    ocp_shut_w |=> soft_off_out && gate_hiz_out)
    else $error("soft turn-off missing on overcurrent shutdown");

  a_soft_min_code: assert property (
    soft_off_out && $past(prog_sink_w) < SINK_CODE_1100MA |-> sink_code_out == SINK_CODE_MIN)
    else $error("soft code not minimum below threshold");

  a_soft_step_down: assert property (
    soft_off_out && $past(prog_sink_w) >= SINK_CODE_1100MA
    |-> sink_code_out == $past(prog_sink_w) - SINK_STEP_DOWN)
    else $error("soft code not stepped down by seven");

  a_warn_status_clr: assert property (
    rd_stat |=> reg_rdata_out[ST_WARN] == $past(warn_s))
    else $error("warning status stayed set");

  a_warn_pin: assert property (
    warn_s && warn_rep_w |=> !fault_out_n)
    else $error("reported warning did not pull pin");

  a_tsd_response: assert property (
    thermal_shutdown_s |=> gate_hiz_out && charge_pump_off_out && !fault_out_n)
    else $error("thermal shutdown response missing");

  a_tsd_sticky: assert property (
    tsd_lat_r && !clear_cmd_w |=> tsd_lat_r)
    else $error("shutdown status dropped without clear");

  a_shunt_masked: assert property (
    oc_r == GDFR_OC_CLEAR && !vds_s && (mode_w == GDFR_OCP_OFF || shunt_overcurrent_disable_w) |=> oc_r == GDFR_OC_CLEAR)
    else $error("masked shunt overcurrent acted");

  a_gdf_latched: assert property (
    gdf_s && !gate_drive_fail_disable_w |-> ##2 gate_hiz_out && !fault_out_n)
    else $error("gate drive fail not latched to hi-z");

  a_trip_hold: assert property (
    oc_r == GDFR_OC_TRIP && !clear_cmd_w && !cbc_clr |=> oc_r == GDFR_OC_TRIP)
    else $error("latched overcurrent released without clear");

  a_retry_release: assert property (
    oc_r == GDFR_OC_RETRY && retry_done_w && !ocp_evt |=> oc_r == GDFR_OC_CLEAR && !vds_lat_r && !sen_lat_r)
    else $error("retry expiry did not release");

  a_report_runs: assert property (
    oc_r == GDFR_OC_TRIP && mode_w == GDFR_OCP_REPORT && !uv_w && !gdf_lat_r && !thermal_shutdown_s
    |=> !gate_hiz_out && !fault_out_n)
    else $error("report mode disturbed drivers");

  a_uv_hiz: assert property (
    uv_hard |=> gate_hiz_out && !fault_out_n)
    else $error("undervoltage did not force hi-z");

  a_pin_release: assert property (
    !fault_any_w [*2] |=> fault_out_n)
    else $error("fault pin held without source");

  c_retry_cycle: cover property (oc_r == GDFR_OC_RETRY ##1 retry_done_w);
  c_trip_clear: cover property (oc_r == GDFR_OC_TRIP && trip_clr);
  c_tsd_recover: cover property ($fell(thermal_shutdown_s) ##2 !gate_hiz_out);
  c_soft_step: cover property (soft_off_out && sink_code_out != SINK_CODE_MIN);

endmodule
`default_nettype wire

// ### design/gdfr_pkg.sv
// gdfr_pkg: constants of the gate driver fault response block.
// assumes a single 40 MHz clock; shared by all gdfr design files.
package gdfr_pkg;

  ////////////////////////////////////////////////////////////////////
  // register port
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;

  // control register fields
  localparam int unsigned CTRL_SINK_LSB = 0;
  localparam int unsigned CTRL_MODE_LSB = 4;
  localparam int unsigned CTRL_SHUNT_OVERCURRENT_DISABLE = 6;
  localparam int unsigned CTRL_GATE_SUPPLY_UV_DISABLE = 7;
  localparam int unsigned CTRL_GATE_DRIVE_FAIL_DISABLE = 8;
  localparam int unsigned CTRL_WARN_REP = 9;
  localparam int unsigned CTRL_CBC_EN = 10;
  localparam int unsigned CTRL_CLEAR = 11;
  localparam logic [15:0] CTRL_RESET = 16'h040f;
  localparam logic [15:0] CTRL_WMASK = 16'h07ff;

  // status register fields
  localparam int unsigned ST_FAULT = 0;
  localparam int unsigned ST_DRAIN_SOURCE_OVERCURRENT = 1;
  localparam int unsigned ST_SHUNT_OVERCURRENT = 2;
  localparam int unsigned ST_GDF = 3;
  localparam int unsigned ST_TSD = 4;
  localparam int unsigned ST_WARN = 5;
  localparam int unsigned ST_UV = 6;
  localparam int unsigned ST_HIZ = 7;

  ////////////////////////////////////////////////////////////////////
  // overcurrent response modes
  typedef enum logic [1:0] {
    GDFR_OCP_LATCH = 2'h0,
    GDFR_OCP_RETRY = 2'h1,
    GDFR_OCP_REPORT = 2'h2,
    GDFR_OCP_OFF = 2'h3
  } gdfr_mode_e;

  // overcurrent state, gray along clear -> trip; clear -> retry flips both bits
  typedef enum logic [1:0] {
    GDFR_OC_CLEAR = 2'b00,
    GDFR_OC_TRIP = 2'b01,
    GDFR_OC_RETRY = 2'b11
  } gdfr_oc_e;

  // sink current codes for the soft turn-off
  localparam logic [3:0] SINK_CODE_1100MA = 4'h9;
  localparam logic [3:0] SINK_CODE_MIN = 4'h0;
  localparam logic [3:0] SINK_STEP_DOWN = 4'h7;

  // timing
  localparam int unsigned CLK_FREQ_MHZ = 40;
  localparam int unsigned RETRY_PERIOD_US = 8000;
  localparam int unsigned RETRY_CYCLES_DFLT = RETRY_PERIOD_US * CLK_FREQ_MHZ;

  // synchronised input vector layout
  localparam int unsigned NUM_PWM = 3;
  localparam int unsigned IN_W = 9 + NUM_PWM;

endpackage

// ### design/gdfr_sync.sv
// gdfr_sync: two flip-flop synchroniser for a vector of levels.
// assumes each bit is an independent level; no word coherency.
`timescale 1ns/1ps
`default_nettype none
module gdfr_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  import gdfr_pkg::*;

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  if (WIDTH < 1)
  begin : g_chk
    $error("gdfr_sync: WIDTH must be at least 1");
  end

  for (genvar i = 0; i < WIDTH; i++)
  begin : g_bit
    always_ff @(posedge sys_clk_in)
    begin
      if (!rst_b_in)
      begin
        meta_r[i] <= 1'b0;
        sync_r[i] <= 1'b0;
      end
      else
      begin
        meta_r[i] <= async_in[i];
        sync_r[i] <= meta_r[i];
      end
    end
  end

  assign sync_out = sync_r;

endmodule
`default_nettype wire

// ### design/gdfr_retry_timer.sv
// gdfr_retry_timer: one-shot down counter, done pulse after CYCLES.
// assumes start_in is a one-cycle pulse; a new start restarts the count.
`timescale 1ns/1ps
`default_nettype none
module gdfr_retry_timer #(
  parameter int unsigned CYCLES = gdfr_pkg::RETRY_CYCLES_DFLT
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic start_in,
  output logic busy_out,
  output logic done_out
);
  import gdfr_pkg::*;

  localparam int unsigned CNT_W = $clog2(CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(CYCLES - 1);

  logic [CNT_W-1:0] cnt_r;
  logic busy_r;
  logic done_r;
  wire cnt_zero = (cnt_r == '0);

  if (CYCLES < 2)
  begin : g_chk
    $error("gdfr_retry_timer: CYCLES must be at least 2");
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      cnt_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      done_r <= busy_r && cnt_zero && !start_in;
      if (start_in)
      begin
        cnt_r <= CNT_LOAD;
        busy_r <= 1'b1;
      end
      else if (busy_r)
      begin
        cnt_r <= cnt_r - CNT_W'(1);
        busy_r <= !cnt_zero;
      end
    end
  end

  assign busy_out = busy_r;
  assign done_out = done_r;

endmodule
`default_nettype wire

// ### dv/gdfr_ctrl_model.sv
// gdfr_ctrl_model: external motor controller beside the fault pin.
// assumes it shares sys_clk_in with the block and drives the pwm pins.
`timescale 1ns/1ps
`default_nettype none
module gdfr_ctrl_model (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic fault_n_in,
  input wire logic restart_in,
  output logic [2:0] pwm_out,
  output logic [7:0] faults_seen_out
);
  logic [2:0] phase_r;
  logic fault_d_r;

  ////////////////////////////////////////////////////////////////////
  // controller restarts switching
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      phase_r <= 3'h0;
    end
    else if (restart_in)
    begin
      phase_r <= 3'h4;
    end
    else if (phase_r != 3'h0)
    begin
      phase_r <= phase_r - 3'h1;
    end
  end

  // all phases rise together, three cycles high, then low
  assign pwm_out = (phase_r > 3'h1) ? 3'b111 : 3'b000;

  ////////////////////////////////////////////////////////////////////
  // counts falling edges of the fault pin
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      fault_d_r <= 1'b1;
      faults_seen_out <= 8'h00;
    end
    else
    begin
      fault_d_r <= fault_n_in;
      if (fault_d_r && !fault_n_in)
      begin
        faults_seen_out <= faults_seen_out + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ### dv/gdfr_fault_resp_tb_top.sv
// gdfr_fault_resp_tb_top: directed test of the fault response block.
// assumes a short retry count; detectors are driven as plain levels.
`timescale 1ns/1ps
`default_nettype none
module gdfr_fault_resp_tb_top;
  import gdfr_pkg::*;
  localparam int unsigned RETRY = 20;
  localparam int LIMIT = 5000;
  logic sys_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic [15:0] rv;
  // 0 vds, 1 shunt, 2 gate fail, 3..6 undervolt, 7 warn, 8 shutdown
  logic [8:0] det = 9'h000;
  logic erp = 1'b0;
  logic kick = 1'b0;
  logic [2:0] pwm;
  logic [7:0] seen;
  logic fault_out_n;
  logic gate_hiz_out;
  logic charge_pump_off_out;
  logic soft_off_out;
  logic [3:0] sink_code_out;
  logic [3:0] outs;
  logic [3:0] codes [3] = '{4'h8, 4'h9, 4'hf};
  logic [3:0] c;
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;

  always #12.5 sys_clk_in = ~sys_clk_in;
  assign outs = {fault_out_n, gate_hiz_out, charge_pump_off_out, soft_off_out};

  gdfr_fault_resp #(.RETRY_CYCLES(RETRY)) i_gdfr_fault_resp (
    .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .drain_source_overcurrent_in(det[0]), .shunt_overcurrent_in(det[1]), .gate_drive_fail_in(det[2]),
    .main_supply_undervolt_in(det[3]), .drain_sense_undervolt_in(det[4]),
    .charge_pump_undervolt_in(det[5]), .lowside_reg_undervolt_in(det[6]),
    .thermal_warn_in(det[7]), .thermal_shutdown_in(det[8]), .pwm_in(pwm),
    .enable_reset_pulse_in(erp), .fault_out_n(fault_out_n), .gate_hiz_out(gate_hiz_out),
    .charge_pump_off_out(charge_pump_off_out), .soft_off_out(soft_off_out),
    .sink_code_out(sink_code_out));

  gdfr_ctrl_model i_gdfr_ctrl_model (
    .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .fault_n_in(fault_out_n),
    .restart_in(kick), .pwm_out(pwm), .faults_seen_out(seen));

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk_in);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a);
    @(posedge sys_clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk_in);
    rd <= 1'b0;
    #1;
    rv = rdata;
  endtask

  task automatic rd_chk(input string what, input logic [3:0] a, input logic [15:0] exp);
    rd_reg(a);
    chk(what, exp, rv);
  endtask

  // detector change, then wait past sync and output stages
  task automatic sd(input int idx, input logic v);
    @(posedge sys_clk_in);
    det[idx] <= v;
    cyc(5);
  endtask

  task automatic chk_out(input string what, input logic [3:0] exp);
    chk(what, {12'h000, exp}, {12'h000, outs});
  endtask

  always @(posedge sys_clk_in)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      fails++;
      finish_test();
    end
  end

  initial
  begin
    repeat (20) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    cyc(2);
    chk_out("reset outs", 4'b1000);
    rd_chk("ctrl reset", ADDR_CTRL, CTRL_RESET);
    rd_chk("status reset", ADDR_STATUS, 16'h0000);
    rd_chk("unmapped", 4'h7, 16'h0000);
    chk("sink reset", 16'h000f, {12'h000, sink_code_out});
    foreach (codes[i])
    begin
      c = codes[i];
      wr_reg(ADDR_CTRL, {12'h040, c});
      sd(0, 1'b1);
      chk_out("latch trip", 4'b0101);
      chk("soft sink", {12'h000, (c >= 4'h9) ? c - 4'h7 : 4'h0}, {12'h000, sink_code_out});
      rd_chk("latch status", ADDR_STATUS, 16'h0083);
      sd(0, 1'b0);
      chk_out("latch hold", 4'b0101);
      wr_reg(ADDR_CTRL, {12'h0c0, c});
      cyc(3);
      chk_out("latch clear", 4'b1000);
      rd_chk("latch cleared", ADDR_STATUS, 16'h0000);
    end
    wr_reg(ADDR_CTRL, 16'h042f);
    sd(1, 1'b1);
    chk_out("report trip", 4'b0000);
    rd_chk("report status", ADDR_STATUS, 16'h0005);
    sd(1, 1'b0);
    @(posedge sys_clk_in);
    kick <= 1'b1;
    @(posedge sys_clk_in);
    kick <= 1'b0;
    cyc(8);
    chk_out("pwm edge clear", 4'b1000);
    // cbc off: pwm edges leave the trip, only a clear command releases it
    wr_reg(ADDR_CTRL, 16'h002f);
    sd(1, 1'b1);
    @(posedge sys_clk_in);
    erp <= 1'b1;
    @(posedge sys_clk_in);
    erp <= 1'b0;
    cyc(3);
    chk_out("ocp clear refused", 4'b0000);
    sd(1, 1'b0);
    @(posedge sys_clk_in);
    kick <= 1'b1;
    @(posedge sys_clk_in);
    kick <= 1'b0;
    cyc(8);
    chk_out("cbc off hold", 4'b0000);
    @(posedge sys_clk_in);
    erp <= 1'b1;
    @(posedge sys_clk_in);
    erp <= 1'b0;
    cyc(3);
    chk_out("ocp report clear", 4'b1000);
    rd_chk("ocp clear status", ADDR_STATUS, 16'h0000);
    wr_reg(ADDR_CTRL, 16'h041f);
    sd(0, 1'b1);
    sd(0, 1'b0);
    chk_out("retry held", 4'b0101);
    cyc(RETRY + 5);
    chk_out("retry done", 4'b1000);
    rd_chk("retry status", ADDR_STATUS, 16'h0000);
    for (int m = 0; m < 2; m++)
    begin
      wr_reg(ADDR_CTRL, (m == 0) ? 16'h043f : 16'h044f);
      sd(1, 1'b1);
      chk_out("shunt ignored", 4'b1000);
      rd_chk("shunt quiet", ADDR_STATUS, 16'h0000);
      sd(1, 1'b0);
    end
    wr_reg(ADDR_CTRL, 16'h040f);
    sd(7, 1'b1);
    chk_out("warn quiet", 4'b1000);
    rd_chk("warn status", ADDR_STATUS, 16'h0020);
    wr_reg(ADDR_CTRL, 16'h060f);
    cyc(3);
    chk_out("warn report", 4'b0000);
    rd_chk("warn fault", ADDR_STATUS, 16'h0021);
    sd(7, 1'b0);
    chk_out("warn gone", 4'b1000);
    rd_chk("warn cleared", ADDR_STATUS, 16'h0000);
    wr_reg(ADDR_CTRL, 16'h07cf);
    sd(8, 1'b1);
    chk_out("shutdown", 4'b0110);
    rd_chk("shutdown status", ADDR_STATUS, 16'h0091);
    sd(8, 1'b0);
    chk_out("shutdown recover", 4'b1000);
    rd_reg(ADDR_STATUS);
    chk("shutdown sticky", 16'h0010, rv & 16'h0010);
    @(posedge sys_clk_in);
    erp <= 1'b1;
    @(posedge sys_clk_in);
    erp <= 1'b0;
    cyc(3);
    rd_chk("enable pulse clear", ADDR_STATUS, 16'h0000);
    for (int k = 3; k < 7; k++)
    begin
      for (int d = 0; d < 2; d++)
      begin
        wr_reg(ADDR_CTRL, (d == 1) ? 16'h048f : 16'h040f);
        sd(k, 1'b1);
        chk_out("undervolt", (k >= 5 && d == 1) ? 4'b1000 : 4'b0100);
        sd(k, 1'b0);
        chk_out("undervolt recover", 4'b1000);
      end
    end
    wr_reg(ADDR_CTRL, 16'h040f);
    sd(2, 1'b1);
    chk_out("gate fail", 4'b0100);
    wr_reg(ADDR_CTRL, 16'h0c0f);
    cyc(3);
    chk_out("clear refused", 4'b0100);
    sd(2, 1'b0);
    chk_out("gate fail held", 4'b0100);
    wr_reg(ADDR_CTRL, 16'h0c0f);
    cyc(3);
    chk_out("gate fail clear", 4'b1000);
    wr_reg(ADDR_CTRL, 16'h050f);
    sd(2, 1'b1);
    chk_out("gate fail off", 4'b1000);
    sd(2, 1'b0);
    chk("fault pin events", 16'h000f, {8'h00, seen});
    finish_test();
  end
endmodule
`default_nettype wire
